/* hw/physeq_ctrl.sv */
// Controller end: AXI4-Lite registers, command slotting, read collection
`timescale 1ns/10ps
`default_nettype none
module physeq_ctrl (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [physeq_pkg::AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [physeq_pkg::AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Interrupt
    output logic irq,
    // PHY link
    physeq_if.ctrl link
);
    localparam int S = physeq_pkg::SLOTS;
    localparam int D = physeq_pkg::DW;
    localparam int IW = physeq_pkg::IRQ_W;

    function automatic logic [31:0] physeq_merge(input logic [31:0] old, input logic [31:0] nw,
                                                 input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic aw_got, next_aw_got, w_got, next_w_got;
    logic [physeq_pkg::AW-1:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid, next_irq;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata, next_wr_word, wr_word, next_rd_word, rd_word, mreg;
    logic crc_en, next_crc_en, cmd_busy, next_cmd_busy, rd_busy, next_rd_busy;
    logic [7:0] cmd, next_cmd;
    logic [IW-1:0] irq_mask, next_mask, irq_stat, next_stat, ev, stat_clr;
    logic [2:0] rd_cnt, next_rd_cnt, rd_need, next_rd_need, min_slot, next_min;
    logic cal_ok_q, cal_fail_q, next_cal_req;
    logic [S-1:0] pend_valid, pend_mask, pend_full, pend_en;
    logic [S*D-1:0] pend_data;
    logic [2*S-1:0] wv, wm, wf, we;
    logic [2*S*D-1:0] wd;
    physeq_pkg::physeq_cmd_t [S-1:0] next_command;
    logic [1:0] op, slot;
    logic [S-1:0] m;
    logic [31:0] status;

    assign op = cmd[physeq_pkg::CMD_OP_LO +: 2];
    assign slot = cmd[physeq_pkg::CMD_SLOT_LO +: 2];
    assign m = cmd[physeq_pkg::CMD_MASK_LO +: S];
    assign status = {16'h0000,
                     link.cal_success ? link.rlat : 6'h00,
                     link.cal_success ? link.wlat : 6'h00,
                     rd_busy, cmd_busy, link.cal_fail, link.cal_success};

    // ======================================
    // Register bus, events and command issue
    always_comb begin
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        next_aw_got = aw_got;
        next_aw_addr = aw_addr;
        next_w_got = w_got;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_crc_en = crc_en;
        next_mask = irq_mask;
        next_wr_word = wr_word;
        next_cmd_busy = cmd_busy;
        next_cmd = cmd;
        next_cal_req = 1'b0;
        mreg = physeq_merge({28'h0000000, irq_mask}, w_data, w_strb);
        ev = '0;
        stat_clr = '0;
        if (bvalid && bready) next_bvalid = 1'b0;
        if (rvalid && rready) next_rvalid = 1'b0;
        if (awvalid && awready) begin
            next_aw_got = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_w_got = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (aw_got && w_got) begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = physeq_pkg::RESP_OKAY;
            case (aw_addr)
                physeq_pkg::REG_CTRL: begin
                    if (w_strb[0]) begin
                        next_crc_en = w_data[physeq_pkg::CTRL_CRC];
                        next_cal_req = w_data[physeq_pkg::CTRL_RECAL];
                    end
                end
                physeq_pkg::REG_CMD: begin
                    if (w_strb[0] && cmd_busy) begin
                        ev[physeq_pkg::IRQ_REFUSED] = 1'b1;
                    end else if (w_strb[0]) begin
                        next_cmd_busy = 1'b1;
                        next_cmd = w_data[7:0];
                    end
                end
                physeq_pkg::REG_WDATA: next_wr_word = physeq_merge(wr_word, w_data, w_strb);
                physeq_pkg::REG_IRQ_MASK: next_mask = mreg[IW-1:0];
                physeq_pkg::REG_IRQ_STAT, physeq_pkg::REG_STATUS, physeq_pkg::REG_RDATA: ;
                default: next_bresp = physeq_pkg::RESP_SLVERR;
            endcase
        end
        if (arvalid && arready) begin
            next_rvalid = 1'b1;
            next_rresp = physeq_pkg::RESP_OKAY;
            case (araddr)
                physeq_pkg::REG_CTRL: next_rdata = {31'h00000000, crc_en};
                physeq_pkg::REG_CMD: next_rdata = {24'h000000, cmd};
                physeq_pkg::REG_WDATA: next_rdata = wr_word;
                physeq_pkg::REG_STATUS: next_rdata = status;
                physeq_pkg::REG_IRQ_STAT: begin
                    next_rdata = {28'h0000000, irq_stat};
                    stat_clr = '1;
                end
                physeq_pkg::REG_IRQ_MASK: next_rdata = {28'h0000000, irq_mask};
                physeq_pkg::REG_RDATA: next_rdata = rd_word;
                default: begin
                    next_rdata = 32'h00000000;
                    next_rresp = physeq_pkg::RESP_SLVERR;
                end
            endcase
        end
        next_arready = !next_rvalid;
        next_awready = !next_aw_got && !next_bvalid;
        next_wready = !next_w_got && !next_bvalid;

        // Read data collection, wanted bytes packed from the low byte up
        next_rd_busy = rd_busy;
        next_rd_cnt = rd_cnt;
        next_rd_need = rd_need;
        next_rd_word = rd_word;
        for (int j = 0; j < S; j++) begin
            if (rd_busy && link.rdata_valid[j]) begin
                next_rd_word[int'(next_rd_cnt[1:0])*D +: D] = link.rdata[j*D +: D];
                next_rd_cnt = next_rd_cnt + 3'h1;
            end
        end
        if (rd_busy && next_rd_cnt == rd_need) begin
            next_rd_busy = 1'b0;
            ev[physeq_pkg::IRQ_RD_DONE] = 1'b1;
        end

        // Slot window: this cycle in the low half, spill-over in the high half
        wv = {{S{1'b0}}, pend_valid};
        wm = {{S{1'b0}}, pend_mask};
        wf = {{S{1'b0}}, pend_full};
        we = {{S{1'b0}}, pend_en};
        wd = {{(S*D){1'b0}}, pend_data};
        next_command = {S{physeq_pkg::PHYSEQ_NOP}};
        next_min = 3'h0;
        if (cmd_busy && !link.cal_success) begin
            next_cmd_busy = 1'b0;
            ev[physeq_pkg::IRQ_REFUSED] = 1'b1;
        end else if (cmd_busy && {1'b0, slot} >= min_slot
                     && !(op == physeq_pkg::CMD_OP_RD && rd_busy)) begin
            next_cmd_busy = 1'b0;
            if (op == physeq_pkg::CMD_OP_WR) begin
                next_command[slot] = physeq_pkg::PHYSEQ_WR;
                for (int j = 0; j < S; j++) begin
                    wv[int'(slot)+j] = 1'b1;
                    wm[int'(slot)+j] = m[j];
                    wd[(int'(slot)+j)*D +: D] = wr_word[j*D +: D];
                end
                next_min = {1'b0, slot} + {2'b00, crc_en};
            end else if (op == physeq_pkg::CMD_OP_RD) begin
                next_command[slot] = physeq_pkg::PHYSEQ_RD;
                next_rd_need = 3'h0;
                for (int j = 0; j < S; j++) begin
                    wf[int'(slot)+j] = 1'b1;
                    we[int'(slot)+j] = m[j];
                    next_rd_need = next_rd_need + {2'b00, m[j]};
                end
                next_rd_cnt = 3'h0;
                next_rd_word = 32'h00000000;
                next_rd_busy = (next_rd_need != 3'h0);
                ev[physeq_pkg::IRQ_RD_DONE] = (next_rd_need == 3'h0);
            end else begin
                ev[physeq_pkg::IRQ_REFUSED] = 1'b1;
            end
        end

        ev[physeq_pkg::IRQ_CAL_OK] = link.cal_success && !cal_ok_q;
        ev[physeq_pkg::IRQ_CAL_FAIL] = link.cal_fail && !cal_fail_q;
        next_stat = (irq_stat & ~stat_clr) | ev;
        next_irq = |(next_stat & next_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
            aw_got <= 1'b0;
            aw_addr <= '0;
            w_got <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            crc_en <= 1'b0;
            irq_mask <= physeq_pkg::IRQ_MASK_RST;
            irq_stat <= '0;
            irq <= 1'b0;
            wr_word <= physeq_pkg::WDATA_RST;
            cmd_busy <= 1'b0;
            cmd <= 8'h00;
            rd_busy <= 1'b0;
            rd_cnt <= 3'h0;
            rd_need <= 3'h0;
            rd_word <= 32'h00000000;
            min_slot <= 3'h0;
            cal_ok_q <= 1'b0;
            cal_fail_q <= 1'b0;
            pend_valid <= '0;
            pend_mask <= '0;
            pend_full <= '0;
            pend_en <= '0;
            pend_data <= '0;
            link.command <= {S{physeq_pkg::PHYSEQ_NOP}};
            link.wdata <= '0;
            link.wdata_valid <= '0;
            link.write_mask_bits <= '0;
            link.rdata_en_full <= '0;
            link.rdata_en <= '0;
            link.crc_en <= 1'b0;
            link.cal_req <= 1'b0;
        end else begin
            awready <= next_awready;
            wready <= next_wready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            arready <= next_arready;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
            aw_got <= next_aw_got;
            aw_addr <= next_aw_addr;
            w_got <= next_w_got;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            crc_en <= next_crc_en;
            irq_mask <= next_mask;
            irq_stat <= next_stat;
            irq <= next_irq;
            wr_word <= next_wr_word;
            cmd_busy <= next_cmd_busy;
            cmd <= next_cmd;
            rd_busy <= next_rd_busy;
            rd_cnt <= next_rd_cnt;
            rd_need <= next_rd_need;
            rd_word <= next_rd_word;
            min_slot <= next_min;
            cal_ok_q <= link.cal_success;
            cal_fail_q <= link.cal_fail;
            pend_valid <= wv[2*S-1:S];
            pend_mask <= wm[2*S-1:S];
            pend_full <= wf[2*S-1:S];
            pend_en <= we[2*S-1:S];
            pend_data <= wd[2*S*D-1:S*D];
            link.command <= next_command;
            link.wdata <= wd[S*D-1:0];
            link.wdata_valid <= wv[S-1:0];
            link.write_mask_bits <= wm[S-1:0];
            link.rdata_en_full <= wf[S-1:0];
            link.rdata_en <= we[S-1:0];
            link.crc_en <= next_crc_en;
            link.cal_req <= next_cal_req;
        end
    end
endmodule
`default_nettype wire

/* hw/physeq_if.sv */
// Link between the memory controller end and the PHY end
`timescale 1ns/10ps
`default_nettype none
interface physeq_if;
    physeq_pkg::physeq_cmd_t [physeq_pkg::SLOTS-1:0] command;
    logic [physeq_pkg::SLOTS*physeq_pkg::DW-1:0] wdata;
    logic [physeq_pkg::SLOTS-1:0] wdata_valid;
    logic [physeq_pkg::SLOTS-1:0] write_mask_bits;
    logic crc_en;
    logic [physeq_pkg::SLOTS-1:0] rdata_en_full;
    logic [physeq_pkg::SLOTS-1:0] rdata_en;
    logic [physeq_pkg::SLOTS*physeq_pkg::DW-1:0] rdata;
    logic [physeq_pkg::SLOTS-1:0] rdata_valid;
    logic cal_req;
    logic cal_success;
    logic cal_fail;
    logic [physeq_pkg::LAT_W-1:0] wlat;
    logic [physeq_pkg::LAT_W-1:0] rlat;

    modport ctrl (
        output command, wdata, wdata_valid, write_mask_bits, crc_en, rdata_en_full, rdata_en,
        output cal_req,
        input rdata, rdata_valid, cal_success, cal_fail, wlat, rlat
    );
    modport phy (
        input command, wdata, wdata_valid, write_mask_bits, crc_en, rdata_en_full, rdata_en,
        input cal_req,
        output rdata, rdata_valid, cal_success, cal_fail, wlat, rlat
    );
endinterface
`default_nettype wire

/* hw/physeq_phy.sv */
// PHY end: calibration status, CRC insertion and read return
`timescale 1ns/10ps
`default_nettype none
module physeq_phy #(
    parameter int CAL_CYCLES = physeq_pkg::CAL_CYCLES,
    parameter logic [physeq_pkg::LAT_W-1:0] WLAT = physeq_pkg::WLAT_DEF,
    parameter logic [physeq_pkg::LAT_W-1:0] RLAT = physeq_pkg::RLAT_DEF
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Calibration outcome
    input wire logic cal_outcome_ok,
    // Memory side
    output logic [physeq_pkg::SLOTS*physeq_pkg::DW-1:0] mem_wr_data,
    output logic [physeq_pkg::SLOTS-1:0] mem_wr_valid,
    output logic [physeq_pkg::SLOTS-1:0] mem_wr_mask,
    output logic [physeq_pkg::SLOTS-1:0] mem_wr_crc,
    input wire logic [physeq_pkg::SLOTS*physeq_pkg::DW-1:0] mem_rd_data,
    // Controller link
    physeq_if.phy link
);
    localparam int S = physeq_pkg::SLOTS;
    localparam int D = physeq_pkg::DW;

    typedef enum {PHYSEQ_CAL, PHYSEQ_PASS, PHYSEQ_FAIL} physeq_cal_t;

    function automatic logic [7:0] physeq_crc8(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ 8'h07) : (r << 1);
        end
        return r;
    endfunction

    physeq_cal_t state, next_state;
    logic [15:0] cal_cnt, next_cal_cnt;
    logic [7:0] crc_acc, next_crc_acc;
    logic in_burst, next_in_burst;
    logic [S*D-1:0] next_wr_data, next_rdata;
    logic [S-1:0] next_wr_valid, next_wr_mask, next_wr_crc, next_rdata_valid;

    // ======================================
    // Calibration sequencing
    always_comb begin
        next_state = state;
        next_cal_cnt = cal_cnt;
        case (state)
            PHYSEQ_CAL: begin
                next_cal_cnt = cal_cnt + 16'h0001;
                if (cal_cnt == 16'(CAL_CYCLES - 1)) begin
                    next_state = cal_outcome_ok ? PHYSEQ_PASS : PHYSEQ_FAIL;
                end
            end
            PHYSEQ_PASS, PHYSEQ_FAIL: next_cal_cnt = 16'h0000;
            default: next_state = PHYSEQ_CAL;
        endcase
        if (link.cal_req) begin
            next_state = PHYSEQ_CAL;
            next_cal_cnt = 16'h0000;
        end
    end

    // ======================================
    // Write path with CRC slot and read return
    always_comb begin
        next_crc_acc = crc_acc;
        next_in_burst = in_burst;
        next_wr_data = '0;
        next_wr_valid = '0;
        next_wr_mask = '0;
        next_wr_crc = '0;
        for (int j = 0; j < S; j++) begin
            if (link.wdata_valid[j]) begin
                next_crc_acc = physeq_crc8(next_crc_acc, link.wdata[j*D +: D]);
                next_wr_data[j*D +: D] = link.wdata[j*D +: D];
                next_wr_valid[j] = 1'b1;
                next_wr_mask[j] = link.write_mask_bits[j];
                next_in_burst = 1'b1;
            end else begin
                if (next_in_burst && link.crc_en) begin
                    next_wr_data[j*D +: D] = next_crc_acc;
                    next_wr_crc[j] = 1'b1;
                end
                next_in_burst = 1'b0;
                next_crc_acc = 8'h00;
            end
        end
        next_rdata = mem_rd_data;
        for (int j = 0; j < S; j++) begin
            if (!link.rdata_en_full[j]) begin
                next_rdata[j*D +: D] = '0;
            end
        end
        next_rdata_valid = link.rdata_en & link.rdata_en_full;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= PHYSEQ_CAL;
            cal_cnt <= 16'h0000;
            crc_acc <= 8'h00;
            in_burst <= 1'b0;
            link.cal_success <= 1'b0;
            link.cal_fail <= 1'b0;
            link.wlat <= '0;
            link.rlat <= '0;
            mem_wr_data <= '0;
            mem_wr_valid <= '0;
            mem_wr_mask <= '0;
            mem_wr_crc <= '0;
            link.rdata <= '0;
            link.rdata_valid <= '0;
        end else begin
            state <= next_state;
            cal_cnt <= next_cal_cnt;
            crc_acc <= next_crc_acc;
            in_burst <= next_in_burst;
            link.cal_success <= (next_state == PHYSEQ_PASS);
            link.cal_fail <= (next_state == PHYSEQ_FAIL);
            link.wlat <= (next_state == PHYSEQ_PASS) ? WLAT : '0;
            link.rlat <= (next_state == PHYSEQ_PASS) ? RLAT : '0;
            mem_wr_data <= next_wr_data;
            mem_wr_valid <= next_wr_valid;
            mem_wr_mask <= next_wr_mask;
            mem_wr_crc <= next_wr_crc;
            link.rdata <= next_rdata;
            link.rdata_valid <= next_rdata_valid;
        end
    end
endmodule
`default_nettype wire

/* hw/physeq_pkg.sv */
// Shared constants, types and register map for the PHY-side sequencing pair
package physeq_pkg;

    // ======================================
    // Link shape
    localparam int SLOTS = 4;
    localparam int DW = 8;
    localparam int LAT_W = 6;
    localparam int AW = 8;

    // ======================================
    // Command encoding on the link
    typedef enum logic [1:0] {
        PHYSEQ_NOP,
        PHYSEQ_WR,
        PHYSEQ_RD
    } physeq_cmd_t;

    // ======================================
    // Register offsets
    localparam logic [AW-1:0] REG_CTRL = 8'h00;
    localparam logic [AW-1:0] REG_CMD = 8'h04;
    localparam logic [AW-1:0] REG_WDATA = 8'h08;
    localparam logic [AW-1:0] REG_STATUS = 8'h0C;
    localparam logic [AW-1:0] REG_IRQ_STAT = 8'h10;
    localparam logic [AW-1:0] REG_IRQ_MASK = 8'h14;
    localparam logic [AW-1:0] REG_RDATA = 8'h18;

    // ======================================
    // Field positions
    localparam int CTRL_CRC = 0;
    localparam int CTRL_RECAL = 1;
    localparam int CMD_OP_LO = 0;
    localparam int CMD_SLOT_LO = 2;
    localparam int CMD_MASK_LO = 4;
    localparam logic [1:0] CMD_OP_WR = 2'h1;
    localparam logic [1:0] CMD_OP_RD = 2'h2;
    localparam int ST_PASS = 0;
    localparam int ST_FAIL = 1;
    localparam int ST_CMD_BUSY = 2;
    localparam int ST_RD_BUSY = 3;
    localparam int ST_WLAT_LO = 4;
    localparam int ST_RLAT_LO = 10;
    localparam int IRQ_CAL_OK = 0;
    localparam int IRQ_CAL_FAIL = 1;
    localparam int IRQ_RD_DONE = 2;
    localparam int IRQ_REFUSED = 3;
    localparam int IRQ_W = 4;

    // ======================================
    // Reset values and counts
    localparam logic [31:0] WDATA_RST = 32'h0000_0000;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam int CAL_CYCLES = 256;
    localparam logic [LAT_W-1:0] WLAT_DEF = 6'h09;
    localparam logic [LAT_W-1:0] RLAT_DEF = 6'h09;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* test/physeq_checker.sv */
// Link assertions for the controller and PHY pair
`timescale 1ns/10ps
`default_nettype none
module physeq_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Controller to PHY
    input wire physeq_pkg::physeq_cmd_t [3:0] command,
    input wire logic [3:0] wdata_valid,
    input wire logic crc_en,
    input wire logic [3:0] rdata_en_full,
    input wire logic [3:0] rdata_en,
    input wire logic cal_req,
    // PHY to controller
    input wire logic cal_success,
    input wire logic cal_fail,
    input wire logic [5:0] wlat,
    input wire logic [5:0] rlat
);
    // ======================================
    // Clocking
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ======================================
    // Properties
    chk_crc_gap: assert property (
        crc_en && command[0] == physeq_pkg::PHYSEQ_WR
        |=> command[0] == physeq_pkg::PHYSEQ_NOP && !wdata_valid[0])
        else $error("Slot after crc write not empty");
    chk_rd_full: assert property (
        command[0] == physeq_pkg::PHYSEQ_RD |-> rdata_en_full == 4'hF)
        else $error("Aligned read enable not full");
    chk_rd_align: assert property (
        command[1] == physeq_pkg::PHYSEQ_RD |-> rdata_en_full == 4'hE ##1 rdata_en_full == 4'h1)
        else $error("Unaligned read enable not shifted");
    chk_rd_want: assert property (
        (rdata_en & ~rdata_en_full) == 4'h0)
        else $error("Wanted enable outside burst");
    chk_cal_boot: assert property (
        $rose(aresetn) |-> (!cal_success && !cal_fail) [*8])
        else $error("Status high early after reset");
    chk_cal_excl: assert property (
        !(cal_success && cal_fail))
        else $error("Pass and fail both high");
    chk_lat_valid: assert property (
        cal_success |-> wlat == physeq_pkg::WLAT_DEF && rlat == physeq_pkg::RLAT_DEF)
        else $error("Latency wrong while passed");
    chk_cal_drop: assert property (
        cal_req |-> ##[1:3] (!cal_success && !cal_fail))
        else $error("Status not cleared on recalibration");
    chk_no_cmd: assert property (
        !cal_success |-> command == '0)
        else $error("Command while not calibrated");
endmodule
`default_nettype wire

/* test/testbench.sv */
// Register-level bench for the controller and PHY pair
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ======================================
    // Signals
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic cal_ok = 1'b1;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [31:0] mem_rd = 32'h44332211;
    logic [3:0] wstrb = 4'hF, mem_wr_crc;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, r;
    int num_errors = 0, comparisons = 0, cyc = 0;
    // ======================================
    // Design and checker
    physeq_if u_physeq_if ();
    physeq_ctrl u_physeq_ctrl (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .irq, .link(u_physeq_if));
    physeq_phy #(.CAL_CYCLES(16)) u_physeq_phy (.aclk, .aresetn, .cal_outcome_ok(cal_ok),
        .mem_wr_data(), .mem_wr_valid(), .mem_wr_mask(), .mem_wr_crc, .mem_rd_data(mem_rd),
        .link(u_physeq_if));
    physeq_checker u_physeq_checker (.aclk, .aresetn, .command(u_physeq_if.command),
        .wdata_valid(u_physeq_if.wdata_valid), .crc_en(u_physeq_if.crc_en),
        .rdata_en_full(u_physeq_if.rdata_en_full), .rdata_en(u_physeq_if.rdata_en),
        .cal_req(u_physeq_if.cal_req), .cal_success(u_physeq_if.cal_success),
        .cal_fail(u_physeq_if.cal_fail), .wlat(u_physeq_if.wlat), .rlat(u_physeq_if.rlat));
    // ======================================
    // Clock and timeout
    initial forever #25 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            end_sim();
        end
    end
    // ======================================
    // Tasks
    task end_sim();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                break;
            end
        end
    endtask
    task axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                resp = rresp;
                break;
            end
        end
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        axr(a, d, r);
        chk(d, exp);
    endtask
    task waitpass();
        repeat (40) begin
            axr(physeq_pkg::REG_STATUS, d, r);
            if (d[0] === 1'b1) break;
        end
    endtask
    // ======================================
    // Tests
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(physeq_pkg::REG_STATUS, 32'h0);
        axw(physeq_pkg::REG_CMD, 32'hF2, r);
        rchk(physeq_pkg::REG_IRQ_STAT, 32'h8);
        waitpass();
        rchk(physeq_pkg::REG_STATUS, {16'h0, physeq_pkg::RLAT_DEF, physeq_pkg::WLAT_DEF, 4'h1});
        rchk(physeq_pkg::REG_IRQ_STAT, 32'h1);
        for (int s = 0; s < 4; s++) begin
            axw(physeq_pkg::REG_IRQ_MASK, (s == 0) ? 32'h0 : 32'h4, r);
            axw(physeq_pkg::REG_CMD, 32'hF2 | (s << 2), r);
            repeat (20) @(posedge aclk);
            chk(irq, (s != 0));
            rchk(physeq_pkg::REG_IRQ_STAT, 32'h4);
            rchk(physeq_pkg::REG_RDATA, (mem_rd >> (8 * s)) | (mem_rd << (32 - 8 * s)));
        end
        chk(irq, 32'h0);
        axw(physeq_pkg::REG_CMD, 32'h36, r);
        repeat (20) @(posedge aclk);
        rchk(physeq_pkg::REG_IRQ_STAT, 32'h4);
        rchk(physeq_pkg::REG_RDATA, 32'h3322);
        axw(physeq_pkg::REG_CTRL, 32'h1, r);
        axw(physeq_pkg::REG_WDATA, 32'hA1B2C3D4, r);
        for (int s = 0; s < 4; s++) begin
            axw(physeq_pkg::REG_CMD, 32'h1 | (s << 2), r);
            repeat (12) begin
                @(posedge aclk);
                if (|mem_wr_crc) break;
            end
            chk(mem_wr_crc, 32'h1 << s);
        end
        axw(physeq_pkg::REG_CTRL, 32'h2, r);
        rchk(physeq_pkg::REG_STATUS, 32'h0);
        waitpass();
        rchk(physeq_pkg::REG_IRQ_STAT, 32'h1);
        cal_ok <= 1'b0;
        axw(physeq_pkg::REG_CTRL, 32'h2, r);
        repeat (40) @(posedge aclk);
        axw(physeq_pkg::REG_CMD, 32'hF2, r);
        rchk(physeq_pkg::REG_STATUS, 32'h2);
        rchk(physeq_pkg::REG_IRQ_STAT, 32'hA);
        axw(8'h40, 32'h0, r);
        chk(r, physeq_pkg::RESP_SLVERR);
        axr(8'h40, d, r);
        chk(r, physeq_pkg::RESP_SLVERR);
        end_sim();
    end
endmodule
`default_nettype wire
